//--- reg_file_model.sv
// register file stand-in: one cell reads zero, the rest nonzero
`timescale 1ns/1ps
module reg_file_model (
  // clock
  input wire logic clk,
  // read port
  input wire logic rd,
  input wire logic [11:0] addr,
  input wire logic [11:0] zero_addr,
  output logic [7:0] rdata
);
  // held after the read strobe, like a real file output
  always_ff @(posedge clk)
  begin
    if (rd)
      rdata <= (addr == zero_addr) ? 8'h00 : 8'hA5;
  end
endmodule : reg_file_model

//--- skip_table_exec.sv
// execution logic for the test-skip and table-write instructions
`timescale 1ns/1ps
`include "skip_table_params.svh"
// Behaviour
// - zero register skips next instruction, two cycles
// - skipped two-word instruction costs three cycles
// - access bit zero uses access bank
// - access bit one uses bank select
// - extended set, access bit zero, offset up to 95 indexed
// - pointer low bits pick holding register
// - mode: none, post-increment, post-decrement, pre-increment
module skip_table_exec #(
  parameter int PTR_W = 21,
  parameter int HOLD_SEL_W = 6,
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // instruction fetch side
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic next_is_two_word,
  output logic flush_fetch,
  output logic busy,
  // configuration
  input wire logic extended_enable,
  input wire logic [3:0] bank_select_reg,
  input wire logic [ADDR_W-1:0] index_base,
  // register file
  output logic [ADDR_W-1:0] general_file_register_addr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // table write path
  input wire logic [7:0] table_data_latch,
  output logic [PTR_W-1:0] program_memory_pointer,
  output logic hold_we,
  output logic [HOLD_SEL_W-1:0] hold_sel,
  output logic [7:0] hold_data
);
  import skip_table_pkg::*;

  // ------------------------------------------------------------------
  // opcode decode
  // ------------------------------------------------------------------
  logic is_test;
  logic is_tblw;
  logic acc_bit;
  logic [7:0] operand;
  logic [1:0] tbl_mode_now;
  assign is_test = instr_valid && (instr[15:9] == `OP_TEST_SKIP_HI);
  assign is_tblw = instr_valid && (instr[15:2] == `OP_TABLE_WRITE_HI);
  assign acc_bit = instr[`ACCESS_BIT];
  assign operand = instr[7:0];
  assign tbl_mode_now = instr[1:0];

  // ------------------------------------------------------------------
  // register address select
  // ------------------------------------------------------------------
  logic indexed;
  logic access_low;
  logic [ADDR_W-1:0] addr_indexed;
  logic [ADDR_W-1:0] addr_banked;
  logic [ADDR_W-1:0] access_addr;
  logic [ADDR_W-1:0] addr_sel;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  assign indexed = extended_enable && !acc_bit && (operand <= `INDEXED_MAX);
  assign access_low = (operand < `ACCESS_SPLIT);
  // wraps inside the address space: a base near the top folds to the bottom
  assign addr_indexed = index_base + ADDR_W'(operand);
  assign addr_banked = ADDR_W'({bank_select_reg, operand});
  // access offsets below 60h are bank zero, 60h and up the special page
  assign access_addr = access_low ? ADDR_W'(operand) :
                       ADDR_W'({`ACCESS_HIGH_BANK, operand});
  assign addr_sel = indexed ? addr_indexed :
                    acc_bit ? addr_banked :
                    access_addr;

  // ------------------------------------------------------------------
  // phase counter and one-hot phase strobes
  // ------------------------------------------------------------------
  phase_t phase_q;
  phase_t phase_d;
  logic [3:0] phase_hot;
  logic cycle_end;
  logic read_phase;
  assign phase_d = phase_q + 2'h1;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_phase
      assign phase_hot[gi] = (phase_q == phase_t'(gi));
    end
  endgenerate
  assign cycle_end = phase_hot[`PHASE_WRITE];
  assign read_phase = phase_hot[`PHASE_READ];

  always_ff @(posedge clk)
  begin
    if (!resetn)
      phase_q <= 2'h0;
    else
      phase_q <= phase_d;
  end

  // ------------------------------------------------------------------
  // address register
  // ------------------------------------------------------------------
  // taken at the end of the decode phase so the file sees a settled
  // address through its read phase; instr must be stable from phase zero
  assign addr_d = phase_hot[`PHASE_DECODE] ? addr_sel : addr_q;
  always_ff @(posedge clk)
  begin
    if (!resetn)
      addr_q <= '0;
    else
      addr_q <= addr_d;
  end

  // ------------------------------------------------------------------
  // instruction cycle sequencing
  // ------------------------------------------------------------------
  exec_state_e state_q;
  exec_state_e state_d;
  logic run_ok;
  logic zero_hit;
  logic skip_go;
  logic tbl_start;
  logic tbl_active;
  logic two_word_q;
  logic two_word_d;
  logic [1:0] tbl_mode_q;
  logic [1:0] tbl_mode;
  assign run_ok = (state_q == ST_RUN);
  assign zero_hit = (reg_rdata == 8'h00);
  // words offered outside the run state are ignored; fetch waits on busy
  assign skip_go = run_ok && is_test && zero_hit && cycle_end;
  assign tbl_start = run_ok && is_tblw && cycle_end;
  assign tbl_active = (state_q == ST_TBLW);
  // fetch may already show the next word during the tail cycle
  assign tbl_mode = tbl_start ? tbl_mode_now : tbl_mode_q;
  assign two_word_d = (run_ok && cycle_end) ? next_is_two_word : two_word_q;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN:
        if (skip_go)
          state_d = ST_SKIP1;
        else if (tbl_start)
          state_d = ST_TBLW;
      ST_SKIP1:
        if (cycle_end)
          state_d = two_word_q ? ST_SKIP2 : ST_RUN;
      ST_SKIP2:
        if (cycle_end)
          state_d = ST_RUN;
      ST_TBLW:
        if (cycle_end)
          state_d = ST_RUN;
      default:
        state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      state_q <= ST_RUN;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      two_word_q <= 1'b0;
    else
      two_word_q <= two_word_d;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      tbl_mode_q <= `MODE_NONE;
    else
      tbl_mode_q <= tbl_mode;
  end

  // ------------------------------------------------------------------
  // outputs to the fetch side and register file
  // ------------------------------------------------------------------
  // register read in phase one of the test cycle
  assign general_file_register_addr = addr_q;
  assign reg_rd = run_ok && is_test && read_phase;
  // discard the prefetched word(s) while skipping
  assign flush_fetch = (state_q == ST_SKIP1) || (state_q == ST_SKIP2);
  assign busy = !run_ok;

  // ------------------------------------------------------------------
  // table write tail
  // ------------------------------------------------------------------
  table_write_unit #(
    .PTR_W(PTR_W),
    .HOLD_SEL_W(HOLD_SEL_W)
  ) u_tbl (
    .clk(clk),
    .resetn(resetn),
    .start(tbl_start),
    .mode(tbl_mode),
    .active(tbl_active),
    .phase(phase_q),
    .table_data_latch(table_data_latch),
    .program_memory_pointer(program_memory_pointer),
    .hold_we(hold_we),
    .hold_sel(hold_sel),
    .hold_data(hold_data)
  );
endmodule : skip_table_exec

//--- skip_table_exec_assertions.sv
// assertions for the skip and table-write block
`timescale 1ns/1ps
module skip_table_exec_assertions #(
  parameter int PTR_W = 21,
  parameter int ADDR_W = 12
) (
  // inputs
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] instr,
  input wire logic extended_enable,
  input wire logic [3:0] bank_select_reg,
  input wire logic [ADDR_W-1:0] index_base,
  // outputs
  input wire logic [ADDR_W-1:0] general_file_register_addr,
  input wire logic reg_rd,
  input wire logic flush_fetch,
  input wire logic busy,
  input wire logic [PTR_W-1:0] program_memory_pointer,
  input wire logic hold_we
);
  wire logic [PTR_W-1:0] p = program_memory_pointer;
  wire logic [ADDR_W-1:0] ga = general_file_register_addr;
  wire logic [7:0] f = instr[7:0];
  wire logic lo = f <= 8'h5F;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  skip_len_a: assert property ($rose(flush_fetch) |-> flush_fetch [*4] ##1
    (!flush_fetch or flush_fetch [*4] ##1 !flush_fetch)) else $error("bad skip length");
  skip_busy_a: assert property (flush_fetch |-> busy) else $error("flush idle");
  write_pulse_a: assert property (hold_we |=> !hold_we) else $error("long write");
  write_end_a: assert property (hold_we |-> $past(busy)) else $error("early write");
  ptr_step_a: assert property ($changed(p) |-> (busy || hold_we || $past(hold_we)) &&
    (p == $past(p) + 1'b1 || p == $past(p) - 1'b1)) else $error("bad pointer step");
  bank_addr_a: assert property (reg_rd && instr[8] |->
    ga == {bank_select_reg, f}) else $error("bad bank address");
  access_addr_a: assert property (reg_rd && !instr[8] && !(extended_enable && lo) |->
    ga == {(f < 8'h60) ? 4'h0 : 4'hF, f}) else $error("bad access address");
  index_addr_a: assert property (reg_rd && !instr[8] && extended_enable && lo |->
    ga == index_base + f) else $error("bad indexed address");
endmodule : skip_table_exec_assertions
bind skip_table_exec skip_table_exec_assertions #(.PTR_W(PTR_W), .ADDR_W(ADDR_W)) chk (
  .clk(clk), .resetn(resetn), .instr(instr), .extended_enable(extended_enable),
  .bank_select_reg(bank_select_reg), .index_base(index_base), .reg_rd(reg_rd),
  .general_file_register_addr(general_file_register_addr), .flush_fetch(flush_fetch),
  .busy(busy), .program_memory_pointer(program_memory_pointer), .hold_we(hold_we));

//--- skip_table_params.svh
// constants for the test-skip and table-write execution block
`ifndef SKIP_TABLE_PARAMS_SVH
`define SKIP_TABLE_PARAMS_SVH
`define OP_TEST_SKIP_HI 7'h33
`define OP_TABLE_WRITE_HI 14'h0003
`define ACCESS_BIT 8
`define INDEXED_MAX 8'h5F
`define ACCESS_SPLIT 8'h60
`define ACCESS_HIGH_BANK 4'hF
`define MODE_NONE 2'h0
`define MODE_POST_INC 2'h1
`define MODE_POST_DEC 2'h2
`define MODE_PRE_INC 2'h3
`define PHASE_DECODE 2'h0
`define PHASE_READ 2'h1
`define PHASE_WRITE 2'h3
`endif

//--- skip_table_pkg.sv
// types for the test-skip and table-write execution block
package skip_table_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SKIP1 = 3'h1,
    ST_SKIP2 = 3'h2,
    ST_TBLW = 3'h3
  } exec_state_e;
  typedef logic [1:0] phase_t;
endpackage : skip_table_pkg

//--- table_write_unit.sv
// table-write tail: pointer update and holding register write
`timescale 1ns/1ps
`include "skip_table_params.svh"
module table_write_unit #(
  parameter int PTR_W = 21,
  parameter int HOLD_SEL_W = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic start,
  input wire logic [1:0] mode,
  input wire logic active,
  input wire skip_table_pkg::phase_t phase,
  // data
  input wire logic [7:0] table_data_latch,
  output logic [PTR_W-1:0] program_memory_pointer,
  output logic hold_we,
  output logic [HOLD_SEL_W-1:0] hold_sel,
  output logic [7:0] hold_data
);
  import skip_table_pkg::*;
  logic [PTR_W-1:0] ptr_q;
  logic [PTR_W-1:0] ptr_d;
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;
  logic rd_now;
  logic wr_now;
  logic [7:0] hold_data_q;
  logic [HOLD_SEL_W-1:0] hold_sel_q;
  logic [7:0] hold_data_d;
  logic [HOLD_SEL_W-1:0] hold_sel_d;
  assign ptr_inc = ptr_q + PTR_W'(1);
  assign ptr_dec = ptr_q - PTR_W'(1);
  // pre-increment lands at start so the write already sees the new address
  assign ptr_d = !start ? ptr_q :
                 (mode == `MODE_PRE_INC) ? ptr_inc :
                 (mode == `MODE_NONE) ? ptr_q : ptr_q;
  assign rd_now = active && (phase == `PHASE_READ);
  assign wr_now = active && (phase == `PHASE_WRITE);
  assign latch_d = rd_now ? table_data_latch : latch_q;
  assign hold_data_d = wr_now ? latch_q : hold_data_q;
  assign hold_sel_d = wr_now ? ptr_q[HOLD_SEL_W-1:0] : hold_sel_q;
  logic [PTR_W-1:0] ptr_after;
  // post-modes step the pointer after the write phase
  assign ptr_after = !wr_now ? ptr_d :
                     (mode == `MODE_POST_INC) ? ptr_inc :
                     (mode == `MODE_POST_DEC) ? ptr_dec : ptr_d;
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ptr_q <= '0;
      latch_q <= 8'h00;
      hold_data_q <= 8'h00;
      hold_sel_q <= '0;
      hold_we <= 1'b0;
    end
    else
    begin
      ptr_q <= ptr_after;
      latch_q <= latch_d;
      hold_data_q <= hold_data_d;
      hold_sel_q <= hold_sel_d;
      hold_we <= wr_now;
    end
  end
  assign program_memory_pointer = ptr_q;
  assign hold_sel = hold_sel_q;
  assign hold_data = hold_data_q;
endmodule : table_write_unit

//--- test_skip_and_table_write_exec_tb_top.sv
// self-checking bench for the skip and table-write block
`timescale 1ns/1ps
module test_skip_and_table_write_exec_tb_top;
  typedef struct {logic x; logic [15:0] w; logic two; logic [11:0] za; int fl;} row_s;
  logic clk, resetn, iv, two_w, flush, busy, ext, rd, we;
  logic [15:0] instr;
  logic [11:0] za, ga;
  logic [7:0] rdata, latch, hdata, dat_seen;
  logic [20:0] ptr;
  logic [5:0] hsel, sel_seen;
  int error_cnt = 0, checks_done = 0;
  logic [31:0] fl, bz, hw;
  logic [7:0] lat_ok = 8'h00;
  logic [3:0] bank = 4'h3;
  logic [11:0] ibase = 12'h120;
  row_s rows [8] = '{'{0, 16'h6610, 0, 12'h010, 4}, '{0, 16'h66A0, 1, 12'hFA0, 8},
    '{0, 16'h6742, 0, 12'h342, 4}, '{0, 16'h6742, 1, 12'h000, 0},
    '{1, 16'h665F, 0, 12'h17F, 4}, '{1, 16'h6660, 1, 12'hF60, 8},
    '{1, 16'h6742, 0, 12'h342, 4}, '{0, 16'h6A10, 0, 12'h010, 0}};
  skip_table_exec uut (.clk(clk), .resetn(resetn), .instr(instr), .instr_valid(iv),
    .next_is_two_word(two_w), .flush_fetch(flush), .busy(busy), .extended_enable(ext),
    .bank_select_reg(bank), .index_base(ibase), .general_file_register_addr(ga),
    .reg_rd(rd), .reg_rdata(rdata), .table_data_latch(latch), .program_memory_pointer(ptr),
    .hold_we(we), .hold_sel(hsel), .hold_data(hdata));
  reg_file_model rf (.clk(clk), .rd(rd), .addr(ga), .zero_addr(za), .rdata(rdata));
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // one instruction slot, then three slots watching the outcome
  task automatic op(logic [15:0] w, logic two);
    instr = w;
    two_w = two;
    iv = 1'b1;
    {fl, bz, hw} = '0;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 13; k++)
    begin
      @(negedge clk);
      if (k == 0)
        iv = 1'b0;
      // latch byte is right only across the read edge of the tail cycle
      if (k == 1)
        latch = lat_ok;
      if (k == 2)
        latch = ~lat_ok;
      fl += flush;
      bz += busy;
      if (we === 1'b1)
      begin
        hw++;
        sel_seen = hsel;
        dat_seen = hdata;
      end
    end
  endtask : op
  task automatic tw(logic [1:0] mode, logic [5:0] sel, logic [20:0] p);
    lat_ok = lat_ok + 8'h11;
    latch = ~lat_ok;
    op(16'h000C | mode, 1'b0);
    check(hw, 1);
    check(bz, 4);
    check(sel_seen, sel);
    check(dat_seen, lat_ok);
    check(ptr, p);
  endtask : tw
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    {resetn, iv, two_w, ext, instr, za, latch} = '0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    foreach (rows[i])
    begin
      ext = rows[i].x;
      za = rows[i].za;
      op(rows[i].w, rows[i].two);
      check(fl, rows[i].fl);
      check(bz, rows[i].fl);
    end
    // bank and index base are live inputs, not fixed defaults
    bank = 4'hC;
    ibase = 12'h7F0;
    za = 12'hC42;
    op(16'h6742, 1'b0);
    check(fl, 4);
    ext = 1'b1;
    za = 12'h7F5;
    op(16'h6605, 1'b0);
    check(fl, 4);
    tw(2'h0, 6'h00, 21'h0);
    tw(2'h1, 6'h00, 21'h1);
    tw(2'h3, 6'h02, 21'h2);
    tw(2'h2, 6'h02, 21'h1);
    // reset mid-run must clear the pointer
    resetn = 1'b0;
    repeat (10) @(negedge clk);
    check(ptr, 21'h0);
    check(busy, 1'b0);
    check(flush, 1'b0);
    check(we, 1'b0);
    resetn = 1'b1;
    tw(2'h3, 6'h01, 21'h1);
    stop_test;
  end
endmodule : test_skip_and_table_write_exec_tb_top
